// ==== core/lsl_pkg.sv ====
// constants for the link status and indicator control block
package lsl_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] LINK_STATE_OFS = 8'h00;  // data-link code, ro
    localparam logic [7:0] PORT_SEL_OFS = 8'h04;    // selected port, rw
    localparam logic [7:0] PORT_STATE_OFS = 8'h08;  // selected port, ro
    localparam logic [7:0] CYC_STATUS_OFS = 8'h0c;  // cyclic status word
    localparam logic [7:0] IND_CMD_OFS = 8'h10;     // indicator commands
    localparam logic [7:0] IND_DIS_OFS = 8'h14;     // disable mask write
    localparam logic [7:0] IND_EN_OFS = 8'h18;      // enable mask write
    localparam logic [7:0] OWN_CTRL_OFS = 8'h1c;    // own error, local stop
    localparam logic [7:0] TIME_LO_OFS = 8'h20;     // time bits 15-0
    localparam logic [7:0] TIME_MID_OFS = 8'h24;    // time bits 31-16
    localparam logic [7:0] TIME_HI_OFS = 8'h28;     // time bits 47-32
    localparam int ADDR_W = 8;                      // decoded address bits

    // data-link state codes
    localparam logic [1:0] LINK_CYCLIC = 2'h2;      // cyclic exchange runs
    localparam logic [1:0] LINK_TOKEN = 2'h1;       // token passing only
    localparam logic [1:0] LINK_ABSENT = 2'h0;      // disconnected

    // port speed and duplex codes
    localparam logic [1:0] SPEED_1G = 2'h0;
    localparam logic [1:0] SPEED_100M = 2'h1;
    localparam logic [1:0] SPEED_10M = 2'h2;
    localparam logic DUPLEX_FULL = 1'b0;
    localparam logic DUPLEX_HALF = 1'b1;

    // parameter-hold field codes
    localparam logic [2:0] PARAM_OK = 3'h1;
    localparam logic [2:0] PARAM_NONE = 3'h2;
    localparam logic [2:0] PARAM_CHECKING = 3'h3;
    localparam logic [2:0] PARAM_BAD = 3'h4;

    // indicator command codes
    localparam logic [1:0] IND_OFF = 2'h0;
    localparam logic [1:0] IND_ON = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;

    // indicator mask bit positions, shared by disable and enable
    localparam int MASK_RUN = 0;
    localparam int MASK_USER2 = 2;
    localparam int MASK_USER1 = 4;
    localparam int MASK_LINK = 6;
    localparam int MASK_FAULT = 8;
    localparam int MASK_LINE1 = 10;
    localparam int MASK_LINE2 = 11;
    localparam logic [15:0] MASK_USED = 16'h0d55;   // listed bits only

    // timing
    localparam int CLK_HZ = 25_000_000;             // system clock rate
    localparam int TIME_STEPS_PER_S = 65536;        // 15.2587890625 us step
    localparam int BLINK_HALF_MS = 500;             // blink half period
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
endpackage : lsl_pkg

// ==== core/lsl_blink_if.sv ====
// shared blink phase between the blink timer and the indicator logic
`timescale 1ns/1ps
interface lsl_blink_if;
    logic phase;  // blink phase, high half lit
    modport src (output phase);
    modport sink (input phase);
endinterface : lsl_blink_if

// ==== core/lsl_blink_timer.sv ====
// free-running blink phase generator shared by all indicators
`timescale 1ns/1ps
module lsl_blink_timer #(
    parameter int HALF_CYC = lsl_pkg::BLINK_HALF_CYC  // cycles per half
) (
    input wire logic clk,        // system clock
    input wire logic srst,       // synchronous reset, high
    lsl_blink_if.src blink       // blink phase out
);
    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_q;  // cycles into current half
    logic phase_q;         // current phase

    // one counter for every indicator keeps blinking in phase
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            phase_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign blink.phase = phase_q;
endmodule : lsl_blink_timer

// ==== core/lsl_status_led.sv ====
// status reporting, indicator control and network time over apb
`timescale 1ns/1ps
// Function
// - link state coded two, one, zero
// - link indicator steady, blinking or dark
// - selected port reports link and speed
// - duplex full zero, half one
// - parameter-hold field three-bit encoding
// - bit three shows parameter check pending
// - bits four, five station range, reserved
// - bits six, seven global, individual stop
// - bit nine cyclic continuation fault
// - bit ten station number clash
// - bit twelve station type invalid
// - bit fourteen disconnected from data link
// - bit fifteen local stop reason
// - indicator commands off, on, blink
// - errors block software indicator requests
// - disable mask turns off indicator control
// - enable mask restores indicator control
// - line fault indicators follow port enables
// - 48-bit network time, three words
// - forced own error holds until reset
module lsl_status_led #(
    parameter int BLINK_CYC = lsl_pkg::BLINK_HALF_CYC  // blink half period
) (
    input wire logic clk,                    // system clock, 25 mhz
    input wire logic srst,                   // synchronous reset, high
    // apb slave
    input wire logic psel,                   // apb select
    input wire logic penable,                // apb access phase
    input wire logic pwrite,                 // apb write
    input wire logic [31:0] paddr,           // apb byte address
    input wire logic [31:0] pwdata,          // apb write data
    output logic [31:0] prdata,              // apb read data
    output logic pready,                     // apb ready
    output logic pslverr,                    // apb error, unmapped
    // network state
    input wire logic tokenPassing,           // token passing ongoing
    input wire logic cyclicActive,           // cyclic exchange running
    input wire logic [1:0] portLinkUp,       // per-port link up
    input wire logic [3:0] portSpeed,        // per-port speed code
    input wire logic [1:0] portDuplex,       // per-port duplex
    input wire logic [1:0] portEnabled,      // per-port in token ring
    // cyclic status sources
    input wire logic paramReceived,          // parameters arrived ok
    input wire logic paramAbnormal,          // parameters arrived bad
    input wire logic parameterCheckPending,  // parameters being checked
    input wire logic stationNumberOutOfRange, // own number invalid
    input wire logic reservedNodeFlag,       // own station reserved
    input wire logic globalStopOrder,        // all stations stopped
    input wire logic individualStopOrder,    // this station stopped
    input wire logic cyclicContinuationFault, // exchange impossible
    input wire logic stationNumberClash,     // duplicate station number
    input wire logic stationTypeInvalid,     // type or size invalid
    // watchdogs
    input wire logic intWatchdogFault,       // internal watchdog
    input wire logic extWatchdogFault,       // external watchdog
    // indicators
    output logic operatingIndicator,         // run indicator
    output logic faultIndicator,             // error indicator
    output logic firstCustomIndicator,       // first user indicator
    output logic secondCustomIndicator,      // second user indicator
    output logic dataLinkIndicator,          // data-link indicator
    output logic firstPortLineFaultIndicator,  // port one line fault
    output logic secondPortLineFaultIndicator  // port two line fault
);
    lsl_blink_if blinkBus ();  // shared blink phase

    // one blink source for all indicators
    lsl_blink_timer #(
        .HALF_CYC(BLINK_CYC)
    ) u_blink (
        .clk(clk),
        .srst(srst),
        .blink(blinkBus.src)
    );

    // ---------------- bus decode ----------------
    wire logic [7:0] addr = paddr[lsl_pkg::ADDR_W-1:0];  // low address
    // high address bits clear
    wire logic upperZero = (paddr[31:lsl_pkg::ADDR_W] == '0);
    // apb phase strobes
    wire logic setupPh = psel & ~penable;          // setup cycle
    wire logic accessWr = psel & penable & pready & pwrite;  // write edge
    // one hit per register
    wire logic hitLink = upperZero & (addr == lsl_pkg::LINK_STATE_OFS);
    wire logic hitPSel = upperZero & (addr == lsl_pkg::PORT_SEL_OFS);
    wire logic hitPState = upperZero & (addr == lsl_pkg::PORT_STATE_OFS);
    wire logic hitCyc = upperZero & (addr == lsl_pkg::CYC_STATUS_OFS);
    wire logic hitCmd = upperZero & (addr == lsl_pkg::IND_CMD_OFS);
    wire logic hitDis = upperZero & (addr == lsl_pkg::IND_DIS_OFS);
    wire logic hitEn = upperZero & (addr == lsl_pkg::IND_EN_OFS);
    wire logic hitOwn = upperZero & (addr == lsl_pkg::OWN_CTRL_OFS);
    wire logic hitT0 = upperZero & (addr == lsl_pkg::TIME_LO_OFS);
    wire logic hitT1 = upperZero & (addr == lsl_pkg::TIME_MID_OFS);
    wire logic hitT2 = upperZero & (addr == lsl_pkg::TIME_HI_OFS);
    // no hit means unmapped
    wire logic hitAny = hitLink | hitPSel | hitPState | hitCyc | hitCmd |
        hitDis | hitEn | hitOwn | hitT0 | hitT1 | hitT2;

    // ---------------- software state ----------------
    logic portSel_q;           // port shown in port state
    logic [1:0] faultCmd_q;    // error indicator command
    logic [1:0] user1Cmd_q;    // first user indicator command
    logic [1:0] user2Cmd_q;    // second user indicator command
    logic runCmd_q;            // run indicator command, off or on
    logic [15:0] ctrlEn_q;     // automatic control enabled per bit
    logic ownError_q;          // forced own-station error, sticky
    logic localStop_q;         // cyclic stop for local reason
    logic [47:0] netTime_q;    // network time counter
    logic [31:0] timeAcc_q;    // fractional step accumulator

    // any condition that overrides software indicator requests
    wire logic errActive = intWatchdogFault | extWatchdogFault |
        ownError_q;

    // ---------------- status coding ----------------
    wire logic [1:0] linkCode = !tokenPassing ? lsl_pkg::LINK_ABSENT :
        (cyclicActive ? lsl_pkg::LINK_CYCLIC : lsl_pkg::LINK_TOKEN);

    // parameter-hold field, checking takes priority over results
    wire logic [2:0] paramHold = parameterCheckPending ?
        lsl_pkg::PARAM_CHECKING : paramAbnormal ? lsl_pkg::PARAM_BAD :
        paramReceived ? lsl_pkg::PARAM_OK : lsl_pkg::PARAM_NONE;

    // cyclic status word, reserved b8, b11, b13 tied low
    wire logic [15:0] cycStatus = {
        localStop_q,
        (linkCode == lsl_pkg::LINK_ABSENT),
        1'b0,
        stationTypeInvalid,
        1'b0,
        stationNumberClash,
        cyclicContinuationFault,
        1'b0,
        individualStopOrder,
        globalStopOrder,
        reservedNodeFlag,
        stationNumberOutOfRange,
        parameterCheckPending,
        paramHold};

    // selected port: duplex, speed, link; reader ignores the first two
    // while link is down, so they pass through unfiltered
    wire logic [1:0] selSpeed = portSel_q ? portSpeed[3:2] :
        portSpeed[1:0];
    // duplex of shown port
    wire logic selDuplex = portDuplex[portSel_q];
    wire logic [3:0] portState = {selDuplex, selSpeed,
        portLinkUp[portSel_q]};

    // ---------------- read mux ----------------
    logic [31:0] rdMux;  // read value of the addressed register
    always_comb begin
        // unused bits read zero
        rdMux = '0;
        unique case (1'b1)
            hitLink: rdMux[1:0] = linkCode;
            hitPSel: rdMux[0] = portSel_q;
            hitPState: rdMux[3:0] = portState;
            hitCyc: rdMux[15:0] = cycStatus;
            hitCmd: rdMux[6:0] = {runCmd_q, user2Cmd_q, user1Cmd_q,
                faultCmd_q};
            hitDis, hitEn: rdMux[15:0] = ctrlEn_q;
            hitOwn: rdMux[1:0] = {localStop_q, ownError_q};
            hitT0: rdMux[15:0] = netTime_q[15:0];
            hitT1: rdMux[15:0] = netTime_q[31:16];
            hitT2: rdMux[15:0] = netTime_q[47:32];
            default: rdMux = '0;
        endcase
    end

    // ---------------- apb answer ----------------
    // ready comes one cycle after setup, so every access has no wait
    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            // answer next cycle
            pready <= setupPh;
            pslverr <= setupPh & ~hitAny;
            // reads only
            prdata <= setupPh & ~pwrite ? rdMux : '0;
        end
    end

    // ---------------- software writes ----------------
    // unlisted bits dropped
    wire logic [15:0] wrMask = pwdata[15:0] & lsl_pkg::MASK_USED;

    // port select and indicator commands
    always_ff @(posedge clk) begin
        if (srst) begin
            portSel_q <= 1'b0;
            faultCmd_q <= lsl_pkg::IND_OFF;
            user1Cmd_q <= lsl_pkg::IND_OFF;
            user2Cmd_q <= lsl_pkg::IND_OFF;
            runCmd_q <= 1'b0;
        end else begin
            // port select
            if (accessWr & hitPSel) begin
                portSel_q <= pwdata[0];
            end
            // four commands
            if (accessWr & hitCmd) begin
                faultCmd_q <= pwdata[1:0];
                user1Cmd_q <= pwdata[3:2];
                user2Cmd_q <= pwdata[5:4];
                runCmd_q <= pwdata[6];
            end
        end
    end

    // control enables: enable sets, disable clears unless an error is active, others hold
    always_ff @(posedge clk) begin
        if (srst) begin
            // all control on
            ctrlEn_q <= lsl_pkg::MASK_USED;
        end else if (accessWr & hitEn) begin
            ctrlEn_q <= ctrlEn_q | wrMask;
        end else if (accessWr & hitDis & ~errActive) begin
            ctrlEn_q <= ctrlEn_q & ~wrMask;
        end
    end

    // own error sticks until reset; local stop set and cleared freely
    always_ff @(posedge clk) begin
        if (srst) begin
            ownError_q <= 1'b0;
            localStop_q <= 1'b0;
        end else if (accessWr & hitOwn) begin
            ownError_q <= ownError_q | pwdata[0];
            localStop_q <= pwdata[1];
        end
    end

    // ---------------- network time ----------------
    // add the step rate each cycle and tick on passing the clock rate,
    // which keeps the long-run step exact at a non-integer ratio
    localparam logic [31:0] ACC_ADD = 32'(lsl_pkg::TIME_STEPS_PER_S);
    localparam logic [31:0] ACC_TOP = 32'(lsl_pkg::CLK_HZ);
    wire logic [31:0] accSum = timeAcc_q + ACC_ADD;
    // one step due
    wire logic timeTick = (accSum >= ACC_TOP);
    // next step value
    wire logic [47:0] timeNext = netTime_q + 48'h1;

    always_ff @(posedge clk) begin
        if (srst) begin
            timeAcc_q <= '0;
        end else begin
            // keep remainder
            timeAcc_q <= timeTick ? accSum - ACC_TOP : accSum;
        end
    end

    // software word writes override the tick for that word
    always_ff @(posedge clk) begin
        if (srst) begin
            netTime_q <= '0;
        end else begin
            // step, then words
            netTime_q <= timeTick ? timeNext : netTime_q;
            if (accessWr & hitT0) begin
                netTime_q[15:0] <= pwdata[15:0];
            end
            if (accessWr & hitT1) begin
                netTime_q[31:16] <= pwdata[15:0];
            end
            if (accessWr & hitT2) begin
                netTime_q[47:32] <= pwdata[15:0];
            end
        end
    end

    // ---------------- indicator resolution ----------------
    wire logic blinkOn = blinkBus.phase;

    // turn a command into a lit level using the shared phase
    function automatic logic cmdLevel(input logic [1:0] cmd,
                                      input logic ph);
        cmdLevel = (cmd == lsl_pkg::IND_ON) |
            ((cmd == lsl_pkg::IND_BLINK) & ph);
    endfunction : cmdLevel

    // error forces the fault indicator steadily on
    wire logic faultLit = errActive | cmdLevel(faultCmd_q, blinkOn);
    // errors keep user and run indicators dark
    wire logic user1Lit = ~errActive & cmdLevel(user1Cmd_q, blinkOn);
    wire logic user2Lit = ~errActive & cmdLevel(user2Cmd_q, blinkOn);
    wire logic runLit = ~errActive & runCmd_q;

    // link indicator from link code
    wire logic linkLit = (linkCode == lsl_pkg::LINK_CYCLIC) |
        ((linkCode == lsl_pkg::LINK_TOKEN) & blinkOn);

    // line fault: the indicator of the port left out lights up
    // ring exists
    wire logic ringUp = (linkCode != lsl_pkg::LINK_ABSENT);
    // only one port enabled
    wire logic line1Lit = ringUp & ~portEnabled[0] & portEnabled[1];
    wire logic line2Lit = ringUp & portEnabled[0] & ~portEnabled[1];

    // registered outputs, dark while automatic control is disabled
    always_ff @(posedge clk) begin
        if (srst) begin
            // all dark
            operatingIndicator <= 1'b0;
            faultIndicator <= 1'b0;
            firstCustomIndicator <= 1'b0;
            secondCustomIndicator <= 1'b0;
            dataLinkIndicator <= 1'b0;
            firstPortLineFaultIndicator <= 1'b0;
            secondPortLineFaultIndicator <= 1'b0;
        end else begin
            // lit and enabled
            operatingIndicator <= runLit &
                ctrlEn_q[lsl_pkg::MASK_RUN];
            faultIndicator <= faultLit &
                ctrlEn_q[lsl_pkg::MASK_FAULT];
            firstCustomIndicator <= user1Lit &
                ctrlEn_q[lsl_pkg::MASK_USER1];
            secondCustomIndicator <= user2Lit &
                ctrlEn_q[lsl_pkg::MASK_USER2];
            dataLinkIndicator <= linkLit &
                ctrlEn_q[lsl_pkg::MASK_LINK];
            firstPortLineFaultIndicator <= line1Lit &
                ctrlEn_q[lsl_pkg::MASK_LINE1];
            secondPortLineFaultIndicator <= line2Lit &
                ctrlEn_q[lsl_pkg::MASK_LINE2];
        end
    end
endmodule : lsl_status_led

// ==== verif/lsl_led_panel.sv ====
// front-panel indicator model counting lit cycles of one indicator
`timescale 1ns/1ps
module lsl_led_panel (
    input wire logic clk, // system clock
    input wire logic clr, // restart the count
    input wire logic [2:0] sel, // indicator under watch
    input wire logic [6:0] leds, // indicator levels, high lit
    output logic [7:0] hiCnt // cycles the watched one was lit
);
    // levels are seen at the clock only, so a blink shows as a partial count
    always_ff @(posedge clk) begin
        if (clr) begin
            hiCnt <= 8'h0; // new window
        end else if (leds[sel]) begin
            hiCnt <= hiCnt + 8'h1; // lit this cycle
        end
    end
endmodule : lsl_led_panel

// ==== verif/lsl_status_led_chk.sv ====
// port assertions for the status and indicator block
`timescale 1ns/1ps
module lsl_status_led_chk (
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [31:0] paddr, // address
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic tokenPassing, // token
    input wire logic [1:0] portEnabled, // ring ports
    input wire logic intWatchdogFault, // watchdog
    input wire logic extWatchdogFault, // watchdog
    input wire logic operatingIndicator, // run
    input wire logic firstCustomIndicator, // user one
    input wire logic secondCustomIndicator, // user two
    input wire logic dataLinkIndicator, // link
    input wire logic firstPortLineFaultIndicator, // line one
    input wire logic secondPortLineFaultIndicator // line two
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // setup phase of an apb transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    a_ready_next: assert property (s_setup |=> pready && penable)
        else $error("ready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (s_setup ##0 paddr[31:8] != 24'h0
        |=> pslverr) else $error("unmapped access not refused");
    a_rsvd_zero: assert property (pready && psel && !pwrite &&
        paddr == {24'h0, lsl_pkg::CYC_STATUS_OFS}
        |-> !prdata[13] && !prdata[11] && !prdata[8])
        else $error("reserved status bit set");
    a_link_dark: assert property (!tokenPassing |=> !dataLinkIndicator)
        else $error("link indicator lit while absent");
    a_line_dark: assert property (
        !tokenPassing || portEnabled == 2'h3
        |=> !firstPortLineFaultIndicator && !secondPortLineFaultIndicator)
        else $error("line fault indicator lit");
    a_user_blocked: assert property (
        intWatchdogFault || extWatchdogFault |=> !operatingIndicator
        && !firstCustomIndicator && !secondCustomIndicator)
        else $error("indicator lit during fault");
endmodule : lsl_status_led_chk
bind lsl_status_led lsl_status_led_chk i_chk (.*);

// ==== verif/lsl_status_led_test.sv ====
// self-checking bench for the status and indicator block
`timescale 1ns/1ps
module lsl_status_led_test;
    logic clk = 1'b0, srst = 1'b1; // clock, reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd; // apb data
    logic pready, pslverr, er, clr = 1'b0; // answers, panel restart
    logic tokenPassing = 1'b0, cyclicActive = 1'b0; // link state
    logic [1:0] portLinkUp = 2'h2, portDuplex = 2'h2, portEnabled = 2'h0;
    logic [3:0] portSpeed = 4'h6; // port one 100m, port zero 10m
    logic paramReceived, paramAbnormal, parameterCheckPending;
    logic stationNumberOutOfRange, reservedNodeFlag, globalStopOrder;
    logic individualStopOrder, cyclicContinuationFault;
    logic stationNumberClash, stationTypeInvalid;
    logic intWatchdogFault = 1'b0, extWatchdogFault = 1'b0; // watchdogs
    logic operatingIndicator, faultIndicator, firstCustomIndicator;
    logic secondCustomIndicator, dataLinkIndicator;
    logic firstPortLineFaultIndicator, secondPortLineFaultIndicator;
    logic [2:0] sel = 3'h0; // watched indicator
    logic [7:0] hiCnt; // lit cycles seen
    logic [9:0] src = 10'h0; // status sources
    logic [9:0] pv [4] = '{10'h3ff, 10'h155, 10'h255, 10'h02a}; // patterns
    int nMismatch = 0, cmpCount = 0; // tallies
    assign {paramReceived, paramAbnormal, parameterCheckPending,
        stationNumberOutOfRange, reservedNodeFlag, globalStopOrder,
        individualStopOrder, cyclicContinuationFault, stationNumberClash,
        stationTypeInvalid} = src;
    lsl_status_led #(.BLINK_CYC(4)) i_dut (.clk, .srst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tokenPassing,
        .cyclicActive, .portLinkUp, .portSpeed, .portDuplex, .portEnabled,
        .paramReceived, .paramAbnormal, .parameterCheckPending,
        .stationNumberOutOfRange, .reservedNodeFlag, .globalStopOrder,
        .individualStopOrder, .cyclicContinuationFault, .stationNumberClash,
        .stationTypeInvalid, .intWatchdogFault, .extWatchdogFault,
        .operatingIndicator, .faultIndicator, .firstCustomIndicator,
        .secondCustomIndicator, .dataLinkIndicator,
        .firstPortLineFaultIndicator, .secondPortLineFaultIndicator);
    lsl_led_panel i_panel (.clk, .clr, .sel, .hiCnt,
        .leds({operatingIndicator, faultIndicator, firstCustomIndicator,
        secondCustomIndicator, dataLinkIndicator,
        firstPortLineFaultIndicator, secondPortLineFaultIndicator}));
    initial forever #20 clk = ~clk;
    // closing report
    task give_verdict();
        $display("compares %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // value comparison
    task cmp(input logic [31:0] g, input logic [31:0] e);
        cmpCount++;
        if (g !== e) begin
            nMismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // one apb transfer
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin
            nMismatch++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task wr(input logic [7:0] o, input logic [31:0] d);
        xfer(1'b1, {24'h0, o}, d);
    endtask : wr
    task rdc(input logic [7:0] o, input logic [31:0] e);
        xfer(1'b0, {24'h0, o}, 32'h0);
        cmp(rd, e);
    endtask : rdc
    // classify: 0 dark, 1 steady, 2 blinking
    task watch(input logic [2:0] s, input logic [1:0] e);
        sel <= s;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (16) @(posedge clk);
        cmp({30'h0, hiCnt == 8'h0 ? 2'h0 : hiCnt > 8'h0d ? 2'h1 : 2'h2},
            {30'h0, e});
    endtask : watch
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc(lsl_pkg::IND_DIS_OFS, 32'h0d55);
        for (int i = 0; i < 3; i++) begin
            tokenPassing <= (i > 0);
            cyclicActive <= (i == 2);
            watch(3'h2, i == 2 ? 2'h1 : i == 1 ? 2'h2 : 2'h0);
            rdc(lsl_pkg::LINK_STATE_OFS, 32'(i));
        end
        wr(lsl_pkg::LINK_STATE_OFS, 32'h0);
        rdc(lsl_pkg::LINK_STATE_OFS, 32'h2);
        wr(lsl_pkg::PORT_SEL_OFS, 32'h0);
        xfer(1'b0, {24'h0, lsl_pkg::PORT_STATE_OFS}, 32'h0);
        cmp({31'h0, rd[0]}, 32'h0);
        portLinkUp <= 2'h3;
        portSpeed <= 4'h4;
        rdc(lsl_pkg::PORT_STATE_OFS, 32'h1);
        wr(lsl_pkg::PORT_SEL_OFS, 32'h1);
        rdc(lsl_pkg::PORT_STATE_OFS, 32'hb);
        wr(lsl_pkg::OWN_CTRL_OFS, 32'h2);
        for (int i = 0; i < 4; i++) begin
            src <= pv[i];
            tokenPassing <= i[0];
            repeat (2) @(posedge clk);
            rdc(lsl_pkg::CYC_STATUS_OFS, {16'h0, 1'b1, !i[0], 1'b0,
                pv[i][0], 1'b0, pv[i][1], pv[i][2], 1'b0, pv[i][3],
                pv[i][4], pv[i][5], pv[i][6], pv[i][7], pv[i][7] ? 3'h3
                : pv[i][8] ? 3'h4 : pv[i][9] ? 3'h1 :
                3'h2});
        end
        for (int m = 0; m < 3; m++) begin
            wr(lsl_pkg::IND_CMD_OFS, {25'h0, m == 1, {3{m[1:0]}}});
            watch(3'h5, m[1:0]);
            watch(3'h4, m[1:0]);
            watch(3'h3, m[1:0]);
            watch(3'h6, {1'b0, m == 1});
        end
        wr(lsl_pkg::IND_CMD_OFS, 32'h54);
        wr(lsl_pkg::IND_DIS_OFS, 32'h10);
        rdc(lsl_pkg::IND_EN_OFS, 32'h0d45);
        watch(3'h4, 2'h0);
        wr(lsl_pkg::IND_DIS_OFS, 32'hffff);
        rdc(lsl_pkg::IND_DIS_OFS, 32'h0);
        wr(lsl_pkg::IND_EN_OFS, 32'h10);
        watch(3'h4, 2'h1);
        wr(lsl_pkg::IND_EN_OFS, 32'hffff);
        rdc(lsl_pkg::IND_EN_OFS, 32'h0d55);
        for (int p = 1; p < 4; p++) begin
            portEnabled <= p[1:0];
            watch(3'h1, {1'b0, p == 2});
            watch(3'h0, {1'b0, p == 1});
        end
        extWatchdogFault <= 1'b1;
        watch(3'h5, 2'h1);
        watch(3'h4, 2'h0);
        watch(3'h6, 2'h0);
        extWatchdogFault <= 1'b0;
        intWatchdogFault <= 1'b1;
        wr(lsl_pkg::IND_DIS_OFS, 32'h100);
        rdc(lsl_pkg::IND_EN_OFS, 32'h0d55);
        intWatchdogFault <= 1'b0;
        wr(lsl_pkg::OWN_CTRL_OFS, 32'h1);
        wr(lsl_pkg::OWN_CTRL_OFS, 32'h0);
        watch(3'h5, 2'h1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        watch(3'h5, 2'h0);
        wr(lsl_pkg::TIME_HI_OFS, 32'h1234);
        wr(lsl_pkg::TIME_MID_OFS, 32'hffff);
        wr(lsl_pkg::TIME_LO_OFS, 32'hffff);
        repeat (400) @(posedge clk);
        rdc(lsl_pkg::TIME_MID_OFS, 32'h0);
        rdc(lsl_pkg::TIME_HI_OFS, 32'h1235);
        xfer(1'b0, 32'h100, 32'h0);
        cmp({rd[31:1], er}, 32'h1);
        give_verdict();
    end
endmodule : lsl_status_led_test
